// [rtl/hbp_pkg.sv]
// Purpose: Shared constants and types for the host bus port (both ends).
// Assumes: 8-bit data, 3-bit register address, single 100 MHz clock.
// Notes:   Pin levels are resolved by the interface from output enables.
package hbp_pkg;
   // =====================================================================
   // Widths
   // =====================================================================
   localparam int DATA_W      = 8;
   localparam int ADDR_W      = 3;
   localparam int LOW_W       = 3;              // Shared address/data lanes
   localparam int SYNC_W      = 3;              // Pin synchroniser depth
   // =====================================================================
   // Levels and timing
   // =====================================================================
   localparam logic DIR_READ  = 1'b1;
   localparam logic DIR_WRITE = 1'b0;
   localparam int CLK_PERIOD_NS   = 10;
   localparam int STROBE_HOLD_NS  = 40;         // Host strobe width
   localparam int STROBE_CYC      = (STROBE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_NS        = 40;         // Host address/data setup
   localparam int SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [3:0] CNT_ZERO  = 4'h0;
   localparam logic [3:0] CNT_ONE   = 4'h1;
   // Bus style chosen by the host
   typedef enum logic {HBP_STYLE_DS, HBP_STYLE_RW} hbp_style_e;
endpackage

// [rtl/hbp_if.sv]
// Purpose: Pin-level carrier between the host and the device port.
// Assumes: Data and address bit 1 drivers supply value and output enable; no tristate in RTL.
// Notes:   Data lines resolve as wired pull-up, as on the real pins.
`timescale 1ns/100ps
interface hbp_if;
   import hbp_pkg::*;
   // Host driven pins, then the device interrupt pin
   logic                reg_addr_in_0;          // Address bit 0, or mux_select_n
   logic                reg_addr_in_1;
   logic                reg_addr_in_1_oe;       // Host leaves it open when muxed
   logic                reg_addr_in_2;          // Address bit 2, or latch strobe
   logic                data_strobe_n;          // Also read_strobe_n
   logic                write_strobe_n;         // Also direction
   logic                chip_select_n;
   logic                hw_reset_in_n;
   logic                irq_out_n;
   // Data lines, split drive
   logic [DATA_W-1:0]   host_data;
   logic                host_data_oe;
   logic [DATA_W-1:0]   dev_data;
   logic                dev_data_oe;
   logic [DATA_W-1:0]   data_bus;
   logic                addr1_pin;
   // Pull-ups win when nobody drives
   assign data_bus  = host_data_oe ? host_data : (dev_data_oe ? dev_data : 8'hff);
   assign addr1_pin = reg_addr_in_1_oe ? reg_addr_in_1 : 1'b1;

   modport host_mp (
      output reg_addr_in_0, reg_addr_in_1, reg_addr_in_1_oe, reg_addr_in_2,
      output data_strobe_n, write_strobe_n, chip_select_n, hw_reset_in_n,
      output host_data, host_data_oe,
      input  data_bus, irq_out_n
   );
   modport dev_mp (
      input  reg_addr_in_0, addr1_pin, reg_addr_in_2,
      input  data_strobe_n, write_strobe_n, chip_select_n, hw_reset_in_n,
      input  data_bus,
      output dev_data, dev_data_oe, irq_out_n
   );
endinterface

// [rtl/hbp_sync.sv]
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to CLK_SYS_I.
// Notes:   Stage one feeds stage two only; the output changes when 2 and 3 agree.
`timescale 1ns/100ps
module hbp_sync
   import hbp_pkg::*;
#(
   parameter int          WIDTH = 1,
   parameter logic [31:0] RST_V = 32'h0
) (
   // Clock and reset
   input  wire logic             CLK_SYS_I,
   input  wire logic             SRST_I,
   // Pins and clean levels
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] lvl_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } hbp_sync_s;
   hbp_sync_s st_ff, nxt_st;

   // =====================================================================
   // Per-bit filter
   // =====================================================================
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = pin_i;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int b = 0; b < WIDTH; b++) begin
         if (st_ff.s2[b] == st_ff.s3[b]) begin
            nxt_st.lvl[b] = st_ff.s3[b];
         end
      end
   end

   // Reset to the idle level, avoiding a false edge at release
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         st_ff <= {4{RST_V[WIDTH-1:0]}};
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign lvl_o = st_ff.lvl;
endmodule

// [rtl/hbp_dev_port.sv]
// Purpose: Device end of the host bus port: decode, latch, strobe, drive.
// Assumes: Host pins are asynchronous and pass the three-stage synchroniser.
// Notes:   Mux mode fixed a few cycles after reset release from mux_select_n; style taken from DS_STYLE_I.
//
// Functional notes
// - Non-muxed: decode three address pins, bit0 LSB
// - Muxed: host lowers mux select, floats bit1
// - Muxed: latch address from low lanes
// - Upper data lines carry data only
// - Non-muxed: all eight lines are data
// - Data strobe low marks the transfer
// - Direction high reads, low writes
// - Read strobe low: device drives data
// - Write strobe low: device takes data
// - Reset pin low resets device
// - Interrupt pin low on enabled event
// - Strobes count only while chip selected; the muxed latch strobe is taken regardless
`timescale 1ns/100ps
module hbp_dev_port
   import hbp_pkg::*;
(
   // Clock and reset
   input  wire logic              CLK_SYS_I,
   input  wire logic              SRST_I,
   // Pins
   hbp_if.dev_mp                  BUS,
   // User side: register access
   input  wire logic              DS_STYLE_I,     // 1: data strobe plus direction
   input  wire logic [DATA_W-1:0] RD_DATA_I,
   output logic      [ADDR_W-1:0] ADDR_O,
   output logic                   RD_STB_O,
   output logic                   WR_STB_O,
   output logic      [DATA_W-1:0] WR_DATA_O,
   output logic                   MUXED_O,
   // User side: reset and interrupt
   input  wire logic              IRQ_REQ_I,      // Enabled condition present
   output logic                   HW_RST_O
);
   // Seven control pins, one spare lane, then the data lines
   localparam int CTL_W = 7;
   localparam int PIN_W = CTL_W + 1 + DATA_W;
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins;
   logic a0, a1, a2, strb_n, wr_dir, cs_n, rst_n;
   logic [DATA_W-1:0] dat;

   typedef struct packed {
      logic              muxed;
      logic              style_ds;
      logic [3:0]        settle;              // Counts out the synchroniser
      logic              ale_q;
      logic [ADDR_W-1:0] addr;
      logic              act_q;
      logic              rd;
      logic              wr;
      logic [DATA_W-1:0] wdat;
      logic [DATA_W-1:0] rdat;
      logic              oe;
      logic              irq_n;
      logic              rst;
   } hbp_dev_s;
   hbp_dev_s st_ff, nxt_st;

   // =====================================================================
   // Pin synchronisers
   // =====================================================================
   // Pin order, top bit first: a0, a1, a2, data strobe, write strobe,
   // chip select, reset, spare, data. Every pin, data included, goes
   // through the same three stages, so address, strobe and data keep
   // their relative timing; the host must therefore hold address and
   // data for several cycles around each strobe edge.
   assign pins_raw = {BUS.reg_addr_in_0, BUS.addr1_pin, BUS.reg_addr_in_2,
                      BUS.data_strobe_n, BUS.write_strobe_n, BUS.chip_select_n,
                      BUS.hw_reset_in_n, 1'b0, BUS.data_bus};
   hbp_sync #(.WIDTH(PIN_W), .RST_V(32'h0001_feff)) hbp_sync_i (
      .CLK_SYS_I (CLK_SYS_I),
      .SRST_I    (SRST_I),
      .pin_i     (pins_raw),
      .lvl_o     (pins)
   );
   assign {a0, a1, a2, strb_n, wr_dir, cs_n, rst_n} = pins[PIN_W-1 -: CTL_W];
   assign dat = pins[DATA_W-1:0];

   // =====================================================================
   // Access decode
   // =====================================================================
   // One combinational pass builds the whole next state. The sections
   // below run in order, so a later one may override an earlier one;
   // the pin reset section comes last on purpose.
   always_comb begin
      logic act;
      logic act_rd;
      logic act_rise;
      logic act_fall;
      act          = 1'b0;
      act_rd       = 1'b0;
      act_rise     = 1'b0;
      act_fall     = 1'b0;
      nxt_st       = st_ff;
      nxt_st.rd    = 1'b0;
      nxt_st.wr    = 1'b0;
      nxt_st.rst   = ~rst_n;
      nxt_st.irq_n = ~IRQ_REQ_I;

      // ==================================================================
      // Strap capture
      // ==================================================================
      // The synchroniser leaves reset at idle levels, so mux select shows
      // its true pin level only a few edges later; sampling at the first
      // edge would always read non-muxed.
      if (st_ff.settle != CNT_ZERO) begin
         nxt_st.settle = st_ff.settle - CNT_ONE;
      end
      if (st_ff.settle == CNT_ONE) begin
         nxt_st.muxed    = ~a0;
         nxt_st.style_ds = DS_STYLE_I;
      end

      // ==================================================================
      // Multiplexed address latch
      // ==================================================================
      // Rising edge of the latch strobe; only the low lanes hold address,
      // the upper lanes are never looked at here
      nxt_st.ale_q = a2;
      if (st_ff.muxed && a2 && !st_ff.ale_q) begin
         nxt_st.addr = dat[LOW_W-1:0];
      end

      // ==================================================================
      // Strobe qualification
      // ==================================================================
      // Neither data nor write strobe counts while chip select is high: strobes meant for
      // another device on the same bus must leave this one alone
      if (!cs_n) begin
         if (st_ff.style_ds) begin
            act    = ~strb_n;
            act_rd = act & (wr_dir == DIR_READ);
         end else begin
            act    = ~strb_n | ~wr_dir;
            act_rd = ~strb_n;
         end
      end
      nxt_st.act_q = act;
      act_rise     = act & ~st_ff.act_q;
      act_fall     = ~act & st_ff.act_q;

      // ==================================================================
      // Transfer events
      // ==================================================================
      // Non-muxed address taken as the access begins
      if (act_rise && !st_ff.muxed) begin
         nxt_st.addr = {a2, a1, a0};
      end
      // Read pulse at the start; the user has one cycle to present data
      if (act_rise && act_rd) begin
         nxt_st.rd = 1'b1;
      end
      // Write data taken at the end of the strobe, when it is settled;
      // a read never ends in a write because the drive flag was up
      if (act_fall && !st_ff.oe) begin
         nxt_st.wr   = 1'b1;
         nxt_st.wdat = dat;
      end
      // Drive only while a selected read strobe stands
      nxt_st.oe = act & act_rd;
      if (st_ff.rd) begin
         nxt_st.rdat = RD_DATA_I;
      end

      // ==================================================================
      // Hardware reset pin
      // ==================================================================
      // Pin reset clears the transfer state but keeps the strap: the bus
      // style belongs to the board, not to the session
      if (!rst_n) begin
         nxt_st.rd   = 1'b0;
         nxt_st.wr   = 1'b0;
         nxt_st.oe   = 1'b0;
         nxt_st.addr = '0;
         nxt_st.wdat = '0;
         nxt_st.rdat = '0;
      end
   end

   // Registered state; strap capture armed by reset
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         st_ff       <= '0;
         // Sync depth plus the edge that makes the level, plus one
         st_ff.settle <= 4'(SYNC_W + 2);
         st_ff.irq_n <= 1'b1;
         st_ff.ale_q <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // =====================================================================
   // Outputs
   // =====================================================================
   // Everything leaves straight from the state register, no logic after it
   assign BUS.dev_data    = st_ff.rdat;
   assign BUS.dev_data_oe = st_ff.oe;
   assign BUS.irq_out_n   = st_ff.irq_n;
   assign ADDR_O          = st_ff.addr;
   assign RD_STB_O        = st_ff.rd;
   assign WR_STB_O        = st_ff.wr;
   assign WR_DATA_O       = st_ff.wdat;
   assign MUXED_O         = st_ff.muxed;
   assign HW_RST_O        = st_ff.rst;
endmodule

// [rtl/hbp_host_port.sv]
// Purpose: Host end: runs one register read or write on the pins.
// Assumes: Style and mux mode are fixed by the user inputs.
// Notes:   Each phase lasts PH_CYC + 1 cycles, PH_CYC being 3 * STROBE_CYC; slow but safe for the sync.
`timescale 1ns/100ps
module hbp_host_port
   import hbp_pkg::*;
#(
   parameter int PH_CYC = 3 * STROBE_CYC
) (
   // Clock and reset
   input  wire logic              CLK_SYS_I,
   input  wire logic              SRST_I,
   // Pins
   hbp_if.host_mp                 BUS,
   // User side
   input  wire logic              MUXED_I,
   input  wire logic              DS_STYLE_I,
   input  wire logic              RESET_REQ_I,
   input  wire logic              REQ_I,
   input  wire logic              WRITE_I,
   input  wire logic [ADDR_W-1:0] ADDR_I,
   input  wire logic [DATA_W-1:0] WDATA_I,
   output logic                   BUSY_O,
   output logic                   DONE_O,
   output logic      [DATA_W-1:0] RDATA_O,
   output logic                   IRQ_O
);
   typedef enum logic [2:0] {H_IDLE, H_ALE, H_SETUP, H_STRB, H_HOLD} hbp_hst_e;
   typedef struct packed {
      hbp_hst_e          st;
      logic [7:0]        cnt;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wd;
      logic [DATA_W-1:0] rd;
      logic              done;
      logic [1:0]        irq;
   } hbp_host_s;
   hbp_host_s st_ff, nxt_st;
   logic      strb;
   logic      cs;

   // =====================================================================
   // Sequencer
   // =====================================================================
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      nxt_st.irq  = {st_ff.irq[0], ~BUS.irq_out_n};
      if (st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - 8'h01;
      end
      case (st_ff.st)
         H_IDLE: begin
            if (REQ_I) begin
               nxt_st.wr   = WRITE_I;
               nxt_st.addr = ADDR_I;
               nxt_st.wd   = WDATA_I;
               nxt_st.cnt  = 8'(PH_CYC);
               nxt_st.st   = MUXED_I ? H_ALE : H_SETUP;
            end
         end
         H_ALE: begin
            if (st_ff.cnt == '0) begin
               nxt_st.cnt = 8'(PH_CYC);
               nxt_st.st  = H_SETUP;
            end
         end
         H_SETUP: begin
            if (st_ff.cnt == '0) begin
               nxt_st.cnt = 8'(PH_CYC);
               nxt_st.st  = H_STRB;
            end
         end
         H_STRB: begin
            if (st_ff.cnt == '0) begin
               nxt_st.rd  = BUS.data_bus;
               nxt_st.cnt = 8'(PH_CYC);
               nxt_st.st  = H_HOLD;
            end
         end
         H_HOLD: begin
            if (st_ff.cnt == '0) begin
               nxt_st.done = 1'b1;
               nxt_st.st   = H_IDLE;
            end
         end
         default: nxt_st.st = H_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         st_ff    <= '0;
         st_ff.st <= H_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // =====================================================================
   // Pin drive
   // =====================================================================
   assign strb = (st_ff.st == H_STRB);
   assign cs   = (st_ff.st == H_SETUP) || strb || (st_ff.st == H_HOLD);
   assign BUS.chip_select_n    = ~cs;
   assign BUS.hw_reset_in_n    = ~RESET_REQ_I;
   // Idle high when non-muxed, so the device never takes a zero address
   // bit for the mux strap while it samples after reset
   assign BUS.reg_addr_in_0    = MUXED_I ? 1'b0 : (cs ? st_ff.addr[0] : 1'b1);
   assign BUS.reg_addr_in_1    = st_ff.addr[1];
   assign BUS.reg_addr_in_1_oe = ~MUXED_I;
   assign BUS.reg_addr_in_2    = MUXED_I ? (st_ff.st == H_ALE) : st_ff.addr[2];
   // Data strobe style: strobe plus direction; else separate strobes
   assign BUS.data_strobe_n    = DS_STYLE_I ? ~strb : ~(strb && !st_ff.wr);
   assign BUS.write_strobe_n   = DS_STYLE_I ? (st_ff.wr ? DIR_WRITE : DIR_READ)
                                            : ~(strb && st_ff.wr);
   // Muxed address on low lanes during latch phase
   assign BUS.host_data        = (st_ff.st == H_ALE) ?
                                 {5'h00, st_ff.addr} : st_ff.wd;
   assign BUS.host_data_oe     = (st_ff.st == H_ALE) || (cs && st_ff.wr);
   assign BUSY_O  = (st_ff.st != H_IDLE);
   assign DONE_O  = st_ff.done;
   assign RDATA_O = st_ff.rd;
   assign IRQ_O   = st_ff.irq[1];
endmodule

// [verification/hbp_properties.sv]
// Purpose: Pin-level checks on the carrier between host and device ends.
// Assumes: One clock, synchronous active-high reset, both ends are design.
// Notes:   Device sees pins through a sync chain, so bounds allow that lag.
`timescale 1ns/100ps
module hbp_properties
   import hbp_pkg::*;
(
   // Clock and reset
   input  wire logic              CLK_SYS_I,
   input  wire logic              SRST_I,
   // Carrier signals
   input  wire logic              chip_select_n,
   input  wire logic              data_strobe_n,
   input  wire logic              write_strobe_n,
   input  wire logic              host_data_oe,
   input  wire logic              dev_data_oe,
   input  wire logic [DATA_W-1:0] dev_data
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);
   // =====================================================================
   // Drive ownership of the data lines
   // =====================================================================
   property p_no_fight;
      !(host_data_oe && dev_data_oe);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
   property p_idle_release;
      chip_select_n [*8] |-> !dev_data_oe;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("drive while idle");
   // Drive must have a selected read strobe behind it, sync lag included
   property p_drive_cause;
      $rose(dev_data_oe) |-> $past(chip_select_n, 2) == 1'b0 && $past(data_strobe_n, 2) == 1'b0;
   endproperty
   a_drive_cause: assert property (p_drive_cause) else $error("drive without strobe");
   property p_write_no_drive;
      (!write_strobe_n) [*8] |-> !dev_data_oe;
   endproperty
   a_write_no_drive: assert property (p_write_no_drive) else $error("drive on write");
   property p_drive_bounded;
      $rose(dev_data_oe) |-> ##[1:40] !dev_data_oe;
   endproperty
   a_drive_bounded: assert property (p_drive_bounded) else $error("drive never ends");
   property p_strobe_selected;
      !data_strobe_n |-> !chip_select_n;
   endproperty
   a_strobe_selected: assert property (p_strobe_selected) else $error("strobe unselected");
   property p_oe_after_reset;
      $past(SRST_I) |-> !dev_data_oe;
   endproperty
   a_oe_after_reset: assert property (p_oe_after_reset) else $error("drive after reset");
   // Read byte must stand while the host may sample it
   property p_data_stable;
      dev_data_oe && $past(dev_data_oe) && $past(dev_data_oe, 2) |-> $stable(dev_data);
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("read byte moves");
endmodule

// [verification/hbp_tb_top.sv]
// Purpose: Runs writes and reads through both ends in every bus style.
// Assumes: Style and mux mode change only across a reset.
// Notes:   Device read data is a fixed function of its decoded address.
`timescale 1ns/100ps
module hbp_tb_top
   import hbp_pkg::*;
;
   logic              clk;
   logic              srst;
   logic              muxed;
   logic              ds_style;
   logic              reset_req;
   logic              req;
   logic              wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              done;
   logic              busy;
   logic [DATA_W-1:0] rdata;
   logic              irq_o;
   logic              irq_req;
   logic [DATA_W-1:0] rd_data;
   logic [ADDR_W-1:0] dev_addr;
   logic              rd_stb;
   logic              wr_stb;
   logic [DATA_W-1:0] dev_wdata;
   logic              muxed_o;
   logic              hw_rst;
   logic [ADDR_W-1:0] cap_addr;
   logic [DATA_W-1:0] cap_wdata;
   int                error_cnt;
   int                num_checks;
   int                wr_seen;
   int                rd_seen;

   function automatic logic [7:0] exp_rd(input logic [2:0] a);
      return {a, ~a, a[1:0]} ^ 8'h5a;
   endfunction

   function automatic logic [7:0] exp_wr(input logic [2:0] a, input logic [1:0] m);
      return {~a, a, a[1:0]} ^ {m, 6'h33};
   endfunction

   hbp_if bus_if ();
   hbp_host_port hbp_host_port_i (.CLK_SYS_I(clk), .SRST_I(srst), .BUS(bus_if.host_mp),
      .MUXED_I(muxed), .DS_STYLE_I(ds_style), .RESET_REQ_I(reset_req), .REQ_I(req),
      .WRITE_I(wr), .ADDR_I(addr), .WDATA_I(wdata), .BUSY_O(busy), .DONE_O(done),
      .RDATA_O(rdata), .IRQ_O(irq_o));
   hbp_dev_port hbp_dev_port_i (.CLK_SYS_I(clk), .SRST_I(srst), .BUS(bus_if.dev_mp),
      .DS_STYLE_I(ds_style), .RD_DATA_I(rd_data), .ADDR_O(dev_addr), .RD_STB_O(rd_stb),
      .WR_STB_O(wr_stb), .WR_DATA_O(dev_wdata), .MUXED_O(muxed_o),
      .IRQ_REQ_I(irq_req), .HW_RST_O(hw_rst));
   hbp_properties hbp_properties_i (.CLK_SYS_I(clk), .SRST_I(srst),
      .chip_select_n(bus_if.chip_select_n), .data_strobe_n(bus_if.data_strobe_n),
      .write_strobe_n(bus_if.write_strobe_n), .host_data_oe(bus_if.host_data_oe),
      .dev_data_oe(bus_if.dev_data_oe), .dev_data(bus_if.dev_data));

   // Register file stand-in: answer depends only on decoded address
   assign rd_data = exp_rd(dev_addr);

   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Catch one-cycle pulses mid-cycle, away from the launching edge
   always @(negedge clk) begin
      if (wr_stb === 1'b1) begin
         wr_seen++;
         cap_addr = dev_addr;
         cap_wdata = dev_wdata;
      end
      if (rd_stb === 1'b1) begin
         rd_seen++;
         cap_addr = dev_addr;
      end
   end

   task automatic print_verdict();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One host access; counts prove exactly one device strobe of the right kind
   task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
      int n;
      int w0;
      int r0;
      w0 = wr_seen;
      r0 = rd_seen;
      @(negedge clk);
      req = 1'b1;
      wr = w;
      addr = a;
      wdata = d;
      @(negedge clk);
      req = 1'b0;
      chk("busy", 8'h01, {7'h00, busy});
      // A second request while busy must be ignored; the address check proves it
      @(negedge clk);
      req = 1'b1;
      addr = ~a;
      @(negedge clk);
      req = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 400) begin
         error_cnt++;
         $display("BAD done expected 1 seen 0");
         print_verdict();
      end else begin
         chk("busy end", 8'h00, {7'h00, busy});
         chk("addr", {5'h00, a}, {5'h00, cap_addr});
         chk("wr count", {7'h00, w}, 8'(wr_seen - w0));
         chk("rd count", {7'h00, ~w}, 8'(rd_seen - r0));
         if (w) begin
            chk("wdata", d, cap_wdata);
         end else begin
            chk("rdata", exp_rd(a), rdata);
         end
      end
   endtask

   // Main sequence: every style, every address, then interrupt and reset pin
   initial begin
      {srst, muxed, ds_style, reset_req, req, wr, irq_req} = 7'h40;
      addr = 3'h0;
      wdata = 8'h00;
      error_cnt = 0;
      num_checks = 0;
      wr_seen = 0;
      rd_seen = 0;
      for (int m = 0; m < 4; m++) begin
         @(negedge clk);
         muxed = m[0];
         ds_style = m[1];
         srst = 1'b1;
         repeat (10) @(negedge clk);
         srst = 1'b0;
         repeat (6) @(negedge clk);
         chk("muxed", {7'h00, muxed}, {7'h00, muxed_o});
         for (int a = 0; a < 8; a++) begin
            access(1'b1, a[2:0], exp_wr(a[2:0], m[1:0]));
            access(1'b0, a[2:0], 8'h00);
         end
      end
      chk("idle bus", 8'hff, bus_if.data_bus);
      @(negedge clk);
      for (int k = 0; k < 2; k++) begin
         irq_req = ~irq_req;
         repeat (6) @(negedge clk);
         chk("irq pin", {7'h00, ~irq_req}, {7'h00, bus_if.irq_out_n});
         chk("irq host", {7'h00, irq_req}, {7'h00, irq_o});
      end
      reset_req = 1'b1;
      repeat (8) @(negedge clk);
      chk("hw reset on", 8'h01, {7'h00, hw_rst});
      chk("hw reset addr", 8'h00, {5'h00, dev_addr});
      reset_req = 1'b0;
      repeat (8) @(negedge clk);
      chk("hw reset off", 8'h00, {7'h00, hw_rst});
      print_verdict();
   end
endmodule
